// ### common/ebid_pkg.sv
`default_nettype none
package ebid_pkg;

  // Fixed upper nibble of the 7-bit target address.
  localparam logic [3:0] ADDR_BASE_NIB = 4'hA;
  // Bit positions of the address byte received after a start.
  localparam int unsigned ADDR_RW_BIT    = 0;
  localparam int unsigned ADDR_SEL_LSB   = 1;
  localparam int unsigned ADDR_SEL_MSB   = 2;
  localparam int unsigned ADDR_STRAP_BIT = 3;
  localparam int unsigned ADDR_NIB_LSB   = 4;

  // Storage depth in bytes and width of the stored index.
  localparam int unsigned MEM_DEPTH = 256;
  localparam int unsigned MEM_AW    = 8;

  // Header pattern held in the first four bytes after reset.
  localparam int unsigned HDR_LEN = 4;
  localparam logic [7:0] HDR_BYTE0 = 8'hAA;
  localparam logic [7:0] HDR_BYTE1 = 8'h55;
  localparam logic [7:0] HDR_BYTE2 = 8'h33;
  localparam logic [7:0] HDR_BYTE3 = 8'hEE;

  // Reset values, and the bit count that completes a byte.
  localparam logic [15:0] PTR_RST   = 16'h0000;
  localparam logic [7:0]  SHIFT_RST = 8'h00;
  localparam logic [3:0]  BCNT_RST  = 4'h0;
  localparam logic [3:0]  BCNT_BYTE = 4'h8;

  // Synchroniser: pins sampled, and their idle level after reset.
  localparam int unsigned SYNC_W   = 6;
  localparam logic [5:0]  SYNC_RST = 6'h3F;
  localparam int unsigned PIN_SCL  = 0;
  localparam int unsigned PIN_SDA  = 1;
  localparam int unsigned PIN_SEL0 = 2;
  localparam int unsigned PIN_SEL1 = 3;
  localparam int unsigned PIN_STRP = 4;
  localparam int unsigned PIN_WP   = 5;

  // Transfer states, Gray coded along the write path.
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_DEV     = 4'h1,
    ST_ACK_DEV = 4'h3,
    ST_ADR_HI  = 4'h2,
    ST_ACK_HI  = 4'h6,
    ST_ADR_LO  = 4'h7,
    ST_ACK_LO  = 4'h5,
    ST_WDAT    = 4'h4,
    ST_ACK_WR  = 4'hC,
    ST_RDAT    = 4'hD,
    ST_RACK    = 4'hF
  } ebid_state_t;

endpackage : ebid_pkg

`default_nettype wire

// ### rtl/ebid_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ebid_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;

  // Two stages; only the second stage leaves this module, so nothing
  // downstream can observe the possibly metastable first stage.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      meta_ff <= RST_VAL;
      sync_o  <= RST_VAL;
    end else begin
      meta_ff <= async_i;
      sync_o  <= meta_ff;
    end
  end

endmodule : ebid_sync

`default_nettype wire

// ### rtl/ebid_eeprom.sv
// Contract
// - Each sold board carries this identity store; host reads it at boot.
// - After the device address, take a two-byte memory address.
// - Other targets may share the bus at different addresses.
// - Writes only while write-protect is low; blocked while it is high.
// - Big-endian content; every memory address reads one single byte.
// - First four bytes reset to the fixed header pattern the host checks; unprotected writes can change them.
`timescale 1ns/1ps
`default_nettype none

module ebid_eeprom (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic [1:0] addr_sel_i,
  input  wire logic       upper_address_strap_i,
  input  wire logic       write_protect_i,
  output logic            addressed_o
);

  logic [ebid_pkg::SYNC_W-1:0] pins_s;
  logic                        scl_q_ff;
  logic                        sda_q_ff;
  logic                        scl_s;
  logic                        sda_s;
  logic                        scl_rise;
  logic                        scl_fall;
  logic                        start_det;
  logic                        stop_det;
  ebid_pkg::ebid_state_t       state_ff;
  logic [3:0]                  bcnt_ff;
  logic [7:0]                  shift_ff;
  logic [15:0]                 ptr_ff;
  logic                        rw_ff;
  logic                        hack_ff;
  logic                        dev_match;
  logic                        wr_ok;
  logic                        byte_done;
  logic [7:0]                  rd_byte;
  logic [7:0]                  hdr_ff [ebid_pkg::HDR_LEN];
  logic [7:0]                  mem [ebid_pkg::MEM_DEPTH];
  logic [ebid_pkg::MEM_AW-1:0] idx;

  // Every pin, straps included, crosses two flops before use.
  ebid_sync #(
    .W       (ebid_pkg::SYNC_W),
    .RST_VAL (ebid_pkg::SYNC_RST)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({write_protect_i, upper_address_strap_i, addr_sel_i,
                 sda_i, scl_i}),
    .sync_o    (pins_s)
  );

  assign scl_s = pins_s[ebid_pkg::PIN_SCL];
  assign sda_s = pins_s[ebid_pkg::PIN_SDA];

  // Delayed copies of the synchronised lines for edge detection.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end

  // Both lines pass the same synchroniser, so their skew is preserved.
  assign scl_rise  = scl_s & ~scl_q_ff;
  assign scl_fall  = ~scl_s & scl_q_ff;
  assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign stop_det  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  assign byte_done = scl_fall && (bcnt_ff == ebid_pkg::BCNT_BYTE);

  // Fixed nibble, strap and switch must all match the received address.
  assign dev_match =
    (shift_ff[7:ebid_pkg::ADDR_NIB_LSB] == ebid_pkg::ADDR_BASE_NIB) &&
    (shift_ff[ebid_pkg::ADDR_STRAP_BIT] ==
     pins_s[ebid_pkg::PIN_STRP]) &&
    (shift_ff[ebid_pkg::ADDR_SEL_MSB:ebid_pkg::ADDR_SEL_LSB] ==
     pins_s[ebid_pkg::PIN_SEL1:ebid_pkg::PIN_SEL0]);

  // Write protect is sampled per byte, so it may change between bytes.
  assign wr_ok = ~pins_s[ebid_pkg::PIN_WP];

  // One byte per address; the header sits in reset-loaded registers.
  assign idx     = ptr_ff[ebid_pkg::MEM_AW-1:0];
  assign rd_byte = (ptr_ff < 16'(ebid_pkg::HDR_LEN)) ?
                   hdr_ff[ptr_ff[1:0]] : mem[idx];

  // Transfer sequencer. A start or stop overrides any state.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_ff <= ebid_pkg::ST_IDLE;
    end else if (start_det) begin
      state_ff <= ebid_pkg::ST_DEV;
    end else if (stop_det) begin
      state_ff <= ebid_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        ebid_pkg::ST_DEV: begin
          if (byte_done) begin
            state_ff <= dev_match ? ebid_pkg::ST_ACK_DEV : ebid_pkg::ST_IDLE;
          end
        end
        ebid_pkg::ST_ACK_DEV: begin
          if (scl_fall) begin
            state_ff <= rw_ff ? ebid_pkg::ST_RDAT : ebid_pkg::ST_ADR_HI;
          end
        end
        ebid_pkg::ST_ADR_HI: begin
          if (byte_done) begin
            state_ff <= ebid_pkg::ST_ACK_HI;
          end
        end
        ebid_pkg::ST_ACK_HI: begin
          if (scl_fall) begin
            state_ff <= ebid_pkg::ST_ADR_LO;
          end
        end
        ebid_pkg::ST_ADR_LO: begin
          if (byte_done) begin
            state_ff <= ebid_pkg::ST_ACK_LO;
          end
        end
        ebid_pkg::ST_ACK_LO: begin
          if (scl_fall) begin
            state_ff <= ebid_pkg::ST_WDAT;
          end
        end
        ebid_pkg::ST_WDAT: begin
          if (byte_done) begin
            // A refused byte is not acknowledged and ends the transfer.
            state_ff <= wr_ok ? ebid_pkg::ST_ACK_WR : ebid_pkg::ST_IDLE;
          end
        end
        ebid_pkg::ST_ACK_WR: begin
          if (scl_fall) begin
            state_ff <= ebid_pkg::ST_WDAT;
          end
        end
        ebid_pkg::ST_RDAT: begin
          if (byte_done) begin
            state_ff <= ebid_pkg::ST_RACK;
          end
        end
        ebid_pkg::ST_RACK: begin
          if (scl_fall) begin
            state_ff <= hack_ff ? ebid_pkg::ST_RDAT : ebid_pkg::ST_IDLE;
          end
        end
        default: begin
          state_ff <= ebid_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Bit counter counts the eight bit rises of a byte. Acknowledge slots
  // are left out, or every later byte would close one bit early.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || start_det || stop_det) begin
      bcnt_ff <= ebid_pkg::BCNT_RST;
    end else if (scl_fall && (bcnt_ff == ebid_pkg::BCNT_BYTE)) begin
      bcnt_ff <= ebid_pkg::BCNT_RST;
    end else if (scl_rise && ((state_ff == ebid_pkg::ST_DEV) ||
                 (state_ff == ebid_pkg::ST_ADR_HI) ||
                 (state_ff == ebid_pkg::ST_ADR_LO) ||
                 (state_ff == ebid_pkg::ST_WDAT) ||
                 (state_ff == ebid_pkg::ST_RDAT))) begin
      bcnt_ff <= bcnt_ff + 4'h1;
    end
  end

  // Shift register: samples on rise when receiving, shifts on fall when
  // sending, and is reloaded with the next byte after an acknowledge.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      shift_ff <= ebid_pkg::SHIFT_RST;
    end else if (state_ff == ebid_pkg::ST_RDAT) begin
      if (scl_fall && (bcnt_ff != ebid_pkg::BCNT_RST)) begin
        shift_ff <= {shift_ff[6:0], 1'b0};
      end
    end else if (((state_ff == ebid_pkg::ST_ACK_DEV) && rw_ff) ||
                 (state_ff == ebid_pkg::ST_RACK)) begin
      if (scl_fall) begin
        shift_ff <= rd_byte;
      end
    end else if (scl_rise) begin
      shift_ff <= {shift_ff[6:0], sda_s};
    end
  end

  // Direction bit of the address byte, and the host's read acknowledge.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rw_ff   <= 1'b0;
      hack_ff <= 1'b0;
    end else begin
      if ((state_ff == ebid_pkg::ST_DEV) && byte_done) begin
        rw_ff <= shift_ff[ebid_pkg::ADDR_RW_BIT];
      end
      if ((state_ff == ebid_pkg::ST_RACK) && scl_rise) begin
        hack_ff <= ~sda_s;
      end
    end
  end

  // Address pointer, big-endian: high byte first, then low byte.
  // It steps once per byte read or written and survives a repeated start.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ptr_ff <= ebid_pkg::PTR_RST;
    end else if (byte_done && (state_ff == ebid_pkg::ST_ADR_HI)) begin
      ptr_ff[15:8] <= shift_ff;
    end else if (byte_done && (state_ff == ebid_pkg::ST_ADR_LO)) begin
      ptr_ff[7:0] <= shift_ff;
    end else if (byte_done && (state_ff == ebid_pkg::ST_WDAT) && wr_ok) begin
      ptr_ff <= ptr_ff + 16'h0001;
    end else if (scl_fall && (((state_ff == ebid_pkg::ST_ACK_DEV) && rw_ff) ||
                 ((state_ff == ebid_pkg::ST_RACK) && hack_ff))) begin
      ptr_ff <= ptr_ff + 16'h0001;
    end
  end

  // Header bytes load the fixed pattern at reset; software may rewrite
  // them while unprotected, which is why protection is worth fitting.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      hdr_ff[0] <= ebid_pkg::HDR_BYTE0;
      hdr_ff[1] <= ebid_pkg::HDR_BYTE1;
      hdr_ff[2] <= ebid_pkg::HDR_BYTE2;
      hdr_ff[3] <= ebid_pkg::HDR_BYTE3;
    end else if (byte_done && (state_ff == ebid_pkg::ST_WDAT) && wr_ok &&
                 (ptr_ff < 16'(ebid_pkg::HDR_LEN))) begin
      hdr_ff[ptr_ff[1:0]] <= shift_ff;
    end
  end

  // Identity storage array; upper pointer bits alias onto it.
  always_ff @(posedge sys_clk_i) begin
    if (byte_done && (state_ff == ebid_pkg::ST_WDAT) && wr_ok) begin
      mem[idx] <= shift_ff;
    end
  end

  // Open-drain data line: pulls low for acknowledges and for zero bits.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || start_det || stop_det) begin
      sda_oe_o <= 1'b0;
    end else if (byte_done) begin
      case (state_ff)
        ebid_pkg::ST_DEV:    sda_oe_o <= dev_match;
        ebid_pkg::ST_WDAT:   sda_oe_o <= wr_ok;
        ebid_pkg::ST_ADR_HI: sda_oe_o <= 1'b1;
        ebid_pkg::ST_ADR_LO: sda_oe_o <= 1'b1;
        default:             sda_oe_o <= 1'b0;
      endcase
    end else if (scl_fall) begin
      case (state_ff)
        ebid_pkg::ST_ACK_DEV: sda_oe_o <= rw_ff & ~rd_byte[7];
        ebid_pkg::ST_RACK:    sda_oe_o <= hack_ff & ~rd_byte[7];
        ebid_pkg::ST_RDAT:    sda_oe_o <= ~shift_ff[6];
        default:              sda_oe_o <= 1'b0;
      endcase
    end
  end

  // The driven level is always low; the line is released to float high.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sda_o       <= 1'b0;
      addressed_o <= 1'b0;
    end else begin
      sda_o       <= 1'b0;
      addressed_o <= (state_ff != ebid_pkg::ST_IDLE) &&
                     (state_ff != ebid_pkg::ST_DEV);
    end
  end

endmodule : ebid_eeprom

`default_nettype wire

// ### verif/ebid_eeprom_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks on the identity store; it cannot see inside.
module ebid_eeprom_sva (
  input wire logic       sys_clk_i,
  input wire logic       reset_n_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic [1:0] addr_sel_i,
  input wire logic       upper_address_strap_i,
  input wire logic       write_protect_i,
  input wire logic       addressed_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  // The first edge after reset must leave the bus alone.
  a_reset_quiet: assert property ($rose(reset_n_i) |->
    !sda_oe_o && !addressed_o) else $error("pins busy after reset");
  a_drive_zero: assert property (sda_o == 1'b0)
    else $error("data drive value not zero");
  // SDA may only move while SCL is low, or it fakes a start or stop.
  a_oe_scl_low: assert property ($changed(sda_oe_o) |->
    !$past(scl_i) && !$past(scl_i, 2)) else $error("sda moved, scl high");
  a_oe_hold: assert property ($fell(scl_i) |->
    $stable(sda_oe_o) [*2]) else $error("sda hold after scl fall short");
  a_oe_held: assert property ($rose(sda_oe_o) |=>
    sda_oe_o [*5]) else $error("sda pull shorter than a bit");
  a_ack_select: assert property ($rose(sda_oe_o) |->
    ##[0:2] addressed_o) else $error("pull without selection");
  a_match_acks: assert property ($rose(addressed_o) |->
    ##[0:40] sda_oe_o) else $error("selection without acknowledge");
  a_frame_ends: assert property (scl_i && $past(scl_i) &&
    $changed(sda_i) |-> ##[1:6] !addressed_o)
    else $error("selection kept over start or stop");

  c_selected: cover property ($rose(addressed_o));
  c_read_low: cover property (addressed_o && sda_oe_o && scl_i);
  c_protect: cover property (write_protect_i && addressed_o);
endmodule : ebid_eeprom_sva

bind ebid_eeprom ebid_eeprom_sva i_ebid_eeprom_sva (
  .sys_clk_i, .reset_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
  .addr_sel_i, .upper_address_strap_i, .write_protect_i, .addressed_o
);
`default_nettype wire

// ### verif/ebid_host.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master model; open drain, so it only pulls SDA low or lets go.
module ebid_host (
  input  wire logic sys_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // Idle bus: both lines released.
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Whole cycles, so every change lands just after a rising edge.
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : wt
  // Start, or repeated start when SCL is low.
  task automatic start();
    sda_low_o <= 1'b0;
    wt(6);
    scl_o <= 1'b1;
    wt(6);
    sda_low_o <= 1'b1;
    wt(6);
    scl_o <= 1'b0;
    wt(6);
  endtask : start
  task automatic stop();
    sda_low_o <= 1'b1;
    wt(6);
    scl_o <= 1'b1;
    wt(6);
    sda_low_o <= 1'b0;
    wt(6);
  endtask : stop
  // Eight bits MSB first, then the acknowledge slot; SDA moves two
  // cycles after SCL falls so the two never change together.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_low_o <= ~tx[i];
      wt(4);
      scl_o <= 1'b1;
      wt(3);
      rx[i] = sda_i;
      wt(3);
      scl_o <= 1'b0;
      wt(2);
    end
  endtask : xfer
endmodule : ebid_host
`default_nettype wire

// ### verif/ebid_eeprom_test.sv
`timescale 1ns/1ps
`default_nettype none
module ebid_eeprom_test;
  localparam int LIMIT = 20000;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [1:0] sel = 2'h0;
  logic       strap = 1'b1;
  logic       wp = 1'b0;
  logic       scl;
  logic       host_low;
  logic       sda_drv;
  logic       oe;
  logic       addressed;
  wire        sda_wire;
  int         mismatches = 0;
  int         num_checks = 0;
  int         cycles = 0;
  // Rows: select, strap, acknowledge expected, 7-bit address probed.
  // A low strap moves the answer below the identity range.
  logic [19:0] rows [9] = '{20'h01154, 20'h11155, 20'h21156,
    20'h31157, 20'h11054, 20'h01050, 20'h00054, 20'h00150, 20'h31077};

  // Pulled up unless someone pulls low.
  assign sda_wire = ~host_low & (oe ? sda_drv : 1'b1);
  always #2.5 sys_clk = ~sys_clk;

  // The only target on this bus, so the identity range is its own.
  ebid_eeprom i_ebid_eeprom (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
    .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_drv), .sda_oe_o(oe),
    .addr_sel_i(sel), .upper_address_strap_i(strap),
    .write_protect_i(wp), .addressed_o(addressed));
  ebid_host i_ebid_host (.sys_clk_i(sys_clk), .sda_i(sda_wire),
    .scl_o(scl), .sda_low_o(host_low));

  task automatic close_out();
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [7:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] b, input logic ack);
    logic [8:0] r;
    i_ebid_host.xfer({b, 1'b1}, r);
    chk("ack", {7'h00, ack}, {7'h00, ~r[0]});
  endtask : wr
  task automatic rd(input logic [7:0] exp, input logic nack);
    logic [8:0] r;
    i_ebid_host.xfer({8'hFF, nack}, r);
    chk("data", exp, r[8:1]);
  endtask : rd
  // Leaves the transfer open so a repeated start can follow.
  task automatic set_ptr(input logic [15:0] a);
    i_ebid_host.start();
    wr(8'hA8, 1'b1);
    wr(a[15:8], 1'b1);
    wr(a[7:0], 1'b1);
  endtask : set_ptr
  task automatic cur_read(input logic [7:0] exp);
    i_ebid_host.start();
    wr(8'hA9, 1'b1);
    rd(exp, 1'b1);
    i_ebid_host.stop();
  endtask : cur_read

  // A hang ends the run as a failure.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (rows[k]) begin
      sel <= rows[k][17:16];
      strap <= rows[k][12];
      i_ebid_host.wt(4);
      i_ebid_host.start();
      wr({rows[k][6:0], 1'b0}, rows[k][8]);
      chk("addressed", {7'h00, rows[k][8]}, {7'h00, addressed});
      i_ebid_host.stop();
    end
    sel <= 2'h0;
    strap <= 1'b1;
    i_ebid_host.wt(4);
    // Fresh pointer streams the header one byte per address.
    i_ebid_host.start();
    wr(8'hA9, 1'b1);
    rd(8'hAA, 1'b0);
    rd(8'h55, 1'b0);
    rd(8'h33, 1'b0);
    rd(8'hEE, 1'b1);
    i_ebid_host.stop();
    set_ptr(16'h0010);
    wr(8'h5A, 1'b1);
    wr(8'h3C, 1'b1);
    i_ebid_host.stop();
    // A protected write is refused and leaves the byte alone.
    wp <= 1'b1;
    set_ptr(16'h0010);
    wr(8'h77, 1'b0);
    i_ebid_host.stop();
    wp <= 1'b0;
    set_ptr(16'h0010);
    cur_read(8'h5A);
    set_ptr(16'h0011);
    cur_read(8'h3C);
    // Writes elsewhere must have left header byte 0 intact.
    set_ptr(16'h0000);
    cur_read(8'hAA);
    reset_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    i_ebid_host.wt(4);
    cur_read(8'hAA);
    close_out();
  end
endmodule : ebid_eeprom_test
`default_nettype wire
